// >>> pkg/bps_cfg.svh
// timing counts, stage positions and stall figures of the branch and stall control
`ifndef BPS_CFG_SVH
`define BPS_CFG_SVH

// ==================================================================
// pipeline geometry
`define BPS_NSTG          10
`define BPS_STG_PD        4
`define BPS_STG_D         5
`define BPS_STG_A         7
`define BPS_STG_EX2       9

// ==================================================================
// branch costs in lost cycles
`define BPS_COST_W        4
`define BPS_COST_NONE     4'h0
`define BPS_COST_BTB_MISS 4'h4
`define BPS_COST_INT_MISP 4'h5
`define BPS_COST_CMP_MISP 4'hA
`define BPS_COST_QUAD     4'h1

// ==================================================================
// dependency stall counts
`define BPS_STL_NONE      4'h0
`define BPS_STL_STAT_CMP  4'h2
`define BPS_STL_STAT_XFR  4'h1
`define BPS_STL_ACS_SAME  4'h0
`define BPS_STL_ACS_CLU   4'h2
`define BPS_STL_TRLD_DSP  4'h1
`define BPS_STL_ACS_WID   4'h1
`define BPS_STL_ACS_SEC   4'h1
`define BPS_STL_CMP_CMP   4'h1
`define BPS_STL_PD_CCMP   4'h4

`endif

// >>> pkg/bps_pkg.sv
// types shared by the branch penalty and stall control
package bps_pkg;

  // ==================================================================
  // instruction class of the line sitting at decode
  typedef enum logic [3:0] {
    BPS_OP_NONE     = 4'h0,
    BPS_OP_COMPUTE  = 4'h1,
    BPS_OP_STAT_RD  = 4'h2,
    BPS_OP_STORE    = 4'h3,
    BPS_OP_ACS      = 4'h4,
    BPS_OP_ACS_COND = 4'h5,
    BPS_OP_TRLD_CND = 4'h6,
    BPS_OP_DESPREAD = 4'h7,
    BPS_OP_CLU      = 4'h8
  } bps_op_t;

endpackage

// >>> design/bps_stall_cnt.sv
// one stall counter: loads once per line, stalls for the loaded number of cycles
`timescale 1ns/1ps
`include "bps_cfg.svh"

module bps_stall_cnt #(
  parameter int CNT_W = `BPS_COST_W
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             trig,
  input  wire logic [CNT_W-1:0] amount,
  input  wire logic             clr,
  output logic                  stall,
  output logic                  fresh
);

  // ==================================================================
  // elaboration check
  if (CNT_W < 1 || CNT_W > 8) begin : g_chk
    $error("bps_stall_cnt: CNT_W out of range");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             done;
  } bps_cnt_st_t;

  bps_cnt_st_t st_q;
  bps_cnt_st_t st_d;

  // first cycle of a stall is combinational, the rest come from the count
  always_comb begin
    fresh = trig & ~st_q.done;
    stall = (fresh & (amount != '0)) | (st_q.cnt != '0);
    st_d  = st_q;
    st_d.done = trig & ~clr;
    if (clr) begin
      st_d.cnt = '0;
    end else if (fresh && amount != '0) begin
      st_d.cnt = amount - CNT_W'(1);
    end else if (st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - CNT_W'(1);
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule // bps_stall_cnt

// >>> design/bps_stall_ctrl.sv
// branch void control and dependency stall control of the ten-stage pipeline
// Behaviour
// - predicted taken, target-buffer miss: void four
// - integer-unit conditions resolved at decode stage
// - compute conditions resolved at second execute stage
// - not-predicted compute branch taken: void ten
// - not-predicted integer branch taken: void five
// - predicted compute branch not taken: void ten
// - predicted integer branch not taken: void five
// - ten stages; memory runs in parallel pipe
// - checks at decode, predecode and access stages
// - stall while a needed result is unready
// - refused bus grant delays the access stage
// - stall counts ignore operand type and size; the code charges a select width change through dec_quad
// - status read then compute: two stalls
// - status read then store same register: one
// - select into first operand, same width: none
// - conditional select then unit reader: two
// - conditional trellis load then despread: one
// - select width change: one stall
// - select into second operand: one stall
// - predicted hit taken free; quad cross adds one
`timescale 1ns/1ps
`include "bps_cfg.svh"

module bps_stall_ctrl #(
  parameter int REG_W = 5
) (
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  input  wire logic                   fetch_valid,
  output logic                        fetch_ready,
  input  wire logic                   pd_int_use_a,
  input  wire logic                   pd_int_use_b,
  input  wire logic [REG_W-1:0]       pd_int_src_a,
  input  wire logic [REG_W-1:0]       pd_int_src_b,
  input  wire logic                   pd_int_wr,
  input  wire logic                   pd_int_wr_ccmp,
  input  wire logic [REG_W-1:0]       pd_int_dst,
  input  wire bps_pkg::bps_op_t       dec_op,
  input  wire logic                   dec_quad,
  input  wire logic                   dec_blk_y,
  input  wire logic [REG_W-1:0]       dec_dst,
  input  wire logic [REG_W-1:0]       dec_src_a,
  input  wire logic [REG_W-1:0]       dec_src_b,
  input  wire logic                   acc_bus_req,
  input  wire logic                   acc_bus_grant,
  input  wire logic                   br_d_valid,
  input  wire logic                   br_d_cmp,
  input  wire logic                   br_d_pred,
  input  wire logic                   br_d_hit,
  input  wire logic                   int_equal_flag,
  input  wire logic                   br_d_tcross,
  input  wire logic                   br_d_scross,
  input  wire logic                   br_x_valid,
  input  wire logic                   br_x_pred,
  input  wire logic                   arith_equal_flag,
  input  wire logic                   br_x_tcross,
  input  wire logic                   br_x_scross,
  output logic [`BPS_NSTG-1:0]        stage_valid,
  output logic [`BPS_NSTG-1:0]        stage_hold,
  output logic [`BPS_NSTG-1:0]        stage_void,
  output logic                        stall_pd,
  output logic                        stall_dec,
  output logic                        stall_acc,
  output logic                        fetch_redirect,
  output logic [`BPS_COST_W-1:0]      void_count
);

  // ==================================================================
  // elaboration check and state
  if (REG_W < 1 || REG_W > 8) begin : g_chk
    $error("bps_stall_ctrl: REG_W out of range");
  end

  localparam int NS = `BPS_NSTG;
  localparam int CW = `BPS_COST_W;

  typedef struct packed {
    bps_pkg::bps_op_t op;
    logic             quad;
    logic             blk_y;
    logic [REG_W-1:0] dst;
  } bps_dprev_t;

  typedef struct packed {
    logic             wr;
    logic             ccmp;
    logic [REG_W-1:0] dst;
  } bps_pprev_t;

  typedef struct packed {
    logic [NS-1:0] vld;
    bps_dprev_t    dp;
    bps_pprev_t    pp;
    logic [CW-1:0] void_cnt;
    logic [CW-1:0] extra;
    logic          redirect;
  } bps_st_t;

  bps_st_t st_q;
  bps_st_t st_d;

  logic [CW-1:0] pd_amt;
  logic [CW-1:0] d_amt;
  logic [CW-1:0] d_cost;
  logic [CW-1:0] x_cost;
  logic [CW-1:0] fl_cost;
  logic [CW-1:0] fl_extra;
  logic          d_go;
  logic          x_go;
  logic          d_fl;
  logic          x_fl;
  logic          fl;
  logic          pen_stall;
  logic          d_fresh;
  logic [NS-1:0] kept;
  logic [NS-1:0] kept_up;
  logic [NS-1:0] hold_up;
  logic          hit_a;
  logic          hit_b;
  logic          cur_clu;
  int            res;

  // ==================================================================
  // integer-unit dependency at predecode
  // predecode integer check
  always_comb begin
    pd_amt = `BPS_STL_NONE;
    if (st_q.pp.wr && st_q.pp.ccmp &&
        ((pd_int_use_a && pd_int_src_a == st_q.pp.dst) ||
         (pd_int_use_b && pd_int_src_b == st_q.pp.dst))) begin
      pd_amt = `BPS_STL_PD_CCMP;
    end
  end

  // ==================================================================
  // compute and trellis dependency at decode; no operand type input, size only through dec_quad
  // dependency table; width only matters for a select after a select
  always_comb begin
    hit_a   = dec_src_a == st_q.dp.dst;
    hit_b   = dec_src_b == st_q.dp.dst;
    cur_clu = dec_op == bps_pkg::BPS_OP_ACS || dec_op == bps_pkg::BPS_OP_ACS_COND ||
              dec_op == bps_pkg::BPS_OP_DESPREAD || dec_op == bps_pkg::BPS_OP_CLU;
    d_amt   = `BPS_STL_NONE;
    case (st_q.dp.op)
      bps_pkg::BPS_OP_STAT_RD: begin
        if (dec_op == bps_pkg::BPS_OP_COMPUTE && dec_blk_y == st_q.dp.blk_y) begin
          d_amt = `BPS_STL_STAT_CMP;
        end else if (dec_op == bps_pkg::BPS_OP_STORE && hit_a) begin
          d_amt = `BPS_STL_STAT_XFR;
        end
      end
      bps_pkg::BPS_OP_ACS_COND: begin
        if (cur_clu && (hit_a || hit_b)) begin
          d_amt = `BPS_STL_ACS_CLU;
        end
      end
      bps_pkg::BPS_OP_TRLD_CND: begin
        if (dec_op == bps_pkg::BPS_OP_DESPREAD) begin
          d_amt = `BPS_STL_TRLD_DSP;
        end
      end
      bps_pkg::BPS_OP_ACS: begin
        if (dec_op == bps_pkg::BPS_OP_ACS || dec_op == bps_pkg::BPS_OP_ACS_COND) begin
          if (hit_b) begin
            d_amt = `BPS_STL_ACS_SEC;
          end else if (hit_a && dec_quad != st_q.dp.quad) begin
            d_amt = `BPS_STL_ACS_WID;
          end else if (hit_a) begin
            d_amt = `BPS_STL_ACS_SAME;
          end
        end
      end
      bps_pkg::BPS_OP_COMPUTE: begin
        if (dec_op == bps_pkg::BPS_OP_COMPUTE && (hit_a || hit_b)) begin
          d_amt = `BPS_STL_CMP_CMP;
        end
      end
      default: begin
        d_amt = `BPS_STL_NONE;
      end
    endcase
  end

  // ==================================================================
  // predecode and decode stall counters; flush clears them so a voided line leaves no stall
  bps_stall_cnt #(.CNT_W(CW)) u_pd_cnt (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .trig    (st_q.vld[`BPS_STG_PD]),
    .amount  (pd_amt),
    .clr     (~stage_hold[`BPS_STG_PD] | fl),
    .stall   (stall_pd),
    .fresh   ()
  );

  bps_stall_cnt #(.CNT_W(CW)) u_d_cnt (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .trig    (st_q.vld[`BPS_STG_D]),
    .amount  (d_amt),
    .clr     (~stage_hold[`BPS_STG_D] | fl),
    .stall   (stall_dec),
    .fresh   (d_fresh)
  );

  // extra lost cycles beyond the voided stages hold fetch after the redirect
  bps_stall_cnt #(.CNT_W(CW)) u_pen_cnt (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .trig    (st_q.redirect),
    .amount  (st_q.extra),
    .clr     (1'b0),
    .stall   (pen_stall),
    .fresh   ()
  );

  assign stall_acc = st_q.vld[`BPS_STG_A] & acc_bus_req & ~acc_bus_grant;

  // ==================================================================
  // branch cost at decode (integer) and second execute (compute)
  always_comb begin
    d_cost = `BPS_COST_NONE;
    x_cost = `BPS_COST_NONE;
    if (br_d_cmp) begin
      // taken-prediction redirect does not wait for the compute flag
      if (br_d_pred) begin
        d_cost = br_d_hit ? `BPS_COST_NONE : `BPS_COST_BTB_MISS;
        d_cost = d_cost + (br_d_tcross ? `BPS_COST_QUAD : `BPS_COST_NONE);
      end
    end else if (br_d_pred && int_equal_flag) begin
      d_cost = (br_d_hit ? `BPS_COST_NONE : `BPS_COST_BTB_MISS) +
               (br_d_tcross ? `BPS_COST_QUAD : `BPS_COST_NONE);
    end else if (br_d_pred != int_equal_flag) begin
      d_cost = `BPS_COST_INT_MISP +
               ((int_equal_flag ? br_d_tcross : br_d_scross) ? `BPS_COST_QUAD
                                                             : `BPS_COST_NONE);
    end
    if (br_x_pred != arith_equal_flag) begin
      x_cost = `BPS_COST_CMP_MISP +
               ((arith_equal_flag ? br_x_tcross : br_x_scross) ? `BPS_COST_QUAD
                                                               : `BPS_COST_NONE);
    end
  end

  // the older branch at second execute wins over one at decode
  always_comb begin
    x_go     = st_q.vld[`BPS_STG_EX2] & br_x_valid;
    d_go     = st_q.vld[`BPS_STG_D] & br_d_valid & ~stage_hold[`BPS_STG_D];
    x_fl     = x_go & (x_cost != `BPS_COST_NONE);
    d_fl     = d_go & (d_cost != `BPS_COST_NONE) & ~x_fl;
    fl       = x_fl | d_fl;
    res      = x_fl ? `BPS_STG_EX2 : `BPS_STG_D;
    fl_cost  = x_fl ? x_cost : d_cost;
    fl_extra = (int'(fl_cost) > res) ? CW'(int'(fl_cost) - res) : '0;
  end

  // ==================================================================
  // hold, void and fetch handshake
  // the fl_cost stages just younger than the resolving stage voided, or all younger stages when fl_cost exceeds the resolving stage index
  // stalled line and younger part held
  always_comb begin
    stage_void = '0;
    stage_hold = '0;
    for (int i = 0; i < NS; i++) begin
      stage_void[i] = fl && (i < res) && ((res - i) <= int'(fl_cost));
      if (stall_acc) begin
        stage_hold[i] = i <= `BPS_STG_A;
      end else if (stall_dec) begin
        stage_hold[i] = i <= `BPS_STG_D;
      end else if (stall_pd) begin
        stage_hold[i] = i <= `BPS_STG_PD;
      end
    end
    fetch_ready = ~stage_hold[0] & ~pen_stall & ~fl;
  end

  // ==================================================================
  // next state: stage shift, previous-line records, redirect
  // ten-stage valid shift
  always_comb begin
    st_d          = st_q;
    st_d.redirect = fl;
    if (fl) begin
      st_d.void_cnt = fl_cost;
      st_d.extra    = fl_extra;
    end
    kept    = st_q.vld & ~stage_void;
    kept_up = {kept[NS-2:0], 1'b0};
    hold_up = {stage_hold[NS-2:0], 1'b0};
    for (int i = 0; i < NS; i++) begin
      if (stage_hold[i]) begin
        // a held line stays put unless it is voided in place
        st_d.vld[i] = kept[i];
      end else if (i == 0) begin
        st_d.vld[i] = fetch_valid & fetch_ready;
      end else if (hold_up[i]) begin
        st_d.vld[i] = 1'b0;
      end else begin
        // a voided line must not move on into the next stage
        st_d.vld[i] = kept_up[i];
      end
    end
    // a bubble leaving a stage clears the record, so no stall is charged
    if (!stage_hold[`BPS_STG_D]) begin
      st_d.dp.op    = (st_q.vld[`BPS_STG_D] && !stage_void[`BPS_STG_D]) ? dec_op
                                                                       : bps_pkg::BPS_OP_NONE;
      st_d.dp.quad  = dec_quad;
      st_d.dp.blk_y = dec_blk_y;
      st_d.dp.dst   = dec_dst;
    end
    if (!stage_hold[`BPS_STG_PD]) begin
      st_d.pp.wr   = st_q.vld[`BPS_STG_PD] & ~stage_void[`BPS_STG_PD] & pd_int_wr;
      st_d.pp.ccmp = pd_int_wr_ccmp;
      st_d.pp.dst  = pd_int_dst;
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign stage_valid    = st_q.vld;
  assign fetch_redirect = st_q.redirect;
  assign void_count     = st_q.void_cnt;

  // ==================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  btb_miss_four_a: assert property (
    (d_go && !br_d_cmp && br_d_pred && !br_d_hit && int_equal_flag && !br_d_tcross && !x_fl)
    |=> fetch_redirect && void_count == 4'h4)
    else $error("taken miss did not void four");
  dec_eval_a: assert property (d_fl |-> stage_void[4] && !stage_void[5] && !stage_void[9])
    else $error("decode branch voided wrong stages");
  ex2_eval_a: assert property (x_fl |-> stage_void[8:0] == 9'h1FF)
    else $error("execute branch did not void younger stages");
  np_cmp_ten_a: assert property (
    (x_go && !br_x_pred && arith_equal_flag && !br_x_tcross)
    |=> void_count == 4'hA && !fetch_ready)
    else $error("compute mispredict not ten");
  np_int_five_a: assert property (
    (d_go && !br_d_cmp && !br_d_pred && int_equal_flag && !br_d_tcross && !x_fl)
    |=> void_count == 4'h5 ##0 fetch_redirect)
    else $error("integer not-predicted not five");
  pred_cmp_nt_a: assert property (
    (x_go && br_x_pred && !arith_equal_flag && !br_x_scross) |=> void_count == 4'hA)
    else $error("compute predicted not-taken not ten");
  pred_int_nt_a: assert property (
    (d_go && !br_d_cmp && br_d_pred && !int_equal_flag && !br_d_scross && !x_fl)
    |=> void_count == 4'h5)
    else $error("integer predicted not-taken not five");
  bus_refuse_a: assert property (
    (stage_valid[7] && acc_bus_req && !acc_bus_grant) |-> stall_acc && stage_hold[7:0] == 8'hFF)
    else $error("refused grant did not hold access");
  stat_two_a: assert property (
    (d_fresh && !fl && st_q.dp.op == bps_pkg::BPS_OP_STAT_RD &&
     dec_op == bps_pkg::BPS_OP_COMPUTE && dec_blk_y == st_q.dp.blk_y)
    |-> stall_dec ##1 (stall_dec || fl) ##1 !stall_dec)
    else $error("status read stall not two");
  acs_free_a: assert property (
    (d_fresh && st_q.dp.op == bps_pkg::BPS_OP_ACS && dec_op == bps_pkg::BPS_OP_ACS &&
     hit_a && !hit_b && dec_quad == st_q.dp.quad) |-> !stall_dec)
    else $error("same-width select stalled");
  quad_cross_a: assert property (
    (d_go && !br_d_cmp && br_d_pred && br_d_hit && int_equal_flag && br_d_tcross && !x_fl)
    |=> void_count == 4'h1)
    else $error("quad crossing not one cycle");
  hold_keep_a: assert property (
    (stall_dec && !fl) |=> stage_valid[5] == $past(stage_valid[5]))
    else $error("stalled decode line lost");
  void_gone_a: assert property (x_fl |=> stage_valid == 10'h000)
    else $error("voided line survived");

endmodule // bps_stall_ctrl

// >>> testbench/bps_stall_ctrl_tb.sv
// self-checking testbench of the branch void and dependency stall control
`timescale 1ns/1ps

module bps_stall_ctrl_tb;
  localparam int RW = 5;
  logic             sys_clk, resetn, fetch_valid, fetch_ready;
  logic             pd_int_use_a, pd_int_use_b, pd_int_wr, pd_int_wr_ccmp;
  logic [RW-1:0]    pd_int_src_a, pd_int_src_b, pd_int_dst;
  bps_pkg::bps_op_t dec_op;
  logic             dec_quad, dec_blk_y, acc_bus_req, acc_bus_grant;
  logic [RW-1:0]    dec_dst, dec_src_a, dec_src_b;
  logic             br_d_valid, br_d_cmp, br_d_pred, br_d_hit, int_equal_flag;
  logic             br_d_tcross, br_d_scross, br_x_valid, br_x_pred;
  logic             arith_equal_flag, br_x_tcross, br_x_scross;
  logic [9:0]       stage_valid, stage_hold, stage_void;
  logic             stall_pd, stall_dec, stall_acc, fetch_redirect;
  logic [3:0]       void_count;
  int               err_total, total_checks;
  int               cyc = 0;

  bps_stall_ctrl #(.REG_W(RW)) u_dut (
    .sys_clk(sys_clk), .resetn(resetn), .fetch_valid(fetch_valid),
    .fetch_ready(fetch_ready), .pd_int_use_a(pd_int_use_a), .pd_int_use_b(pd_int_use_b),
    .pd_int_src_a(pd_int_src_a), .pd_int_src_b(pd_int_src_b), .pd_int_wr(pd_int_wr),
    .pd_int_wr_ccmp(pd_int_wr_ccmp), .pd_int_dst(pd_int_dst), .dec_op(dec_op),
    .dec_quad(dec_quad), .dec_blk_y(dec_blk_y), .dec_dst(dec_dst),
    .dec_src_a(dec_src_a), .dec_src_b(dec_src_b), .acc_bus_req(acc_bus_req),
    .acc_bus_grant(acc_bus_grant), .br_d_valid(br_d_valid), .br_d_cmp(br_d_cmp),
    .br_d_pred(br_d_pred), .br_d_hit(br_d_hit), .int_equal_flag(int_equal_flag),
    .br_d_tcross(br_d_tcross), .br_d_scross(br_d_scross), .br_x_valid(br_x_valid),
    .br_x_pred(br_x_pred), .arith_equal_flag(arith_equal_flag),
    .br_x_tcross(br_x_tcross), .br_x_scross(br_x_scross), .stage_valid(stage_valid),
    .stage_hold(stage_hold), .stage_void(stage_void), .stall_pd(stall_pd),
    .stall_dec(stall_dec), .stall_acc(stall_acc), .fetch_redirect(fetch_redirect),
    .void_count(void_count)
  );

  // ==================================================================
  // clock and reporting
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // a hung handshake must not stall the run forever
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      complete_run();
    end
  end

  // ==================================================================
  // scenarios
  // decode pair: line one then dependent line two, count stall cycles
  task automatic dep(input bps_pkg::bps_op_t o1, input logic q1, y1, input logic [4:0] d1,
                     input bps_pkg::bps_op_t o2, input logic q2, y2,
                     input logic [4:0] a2, b2, input logic [3:0] n);
    int c;
    c = 0;
    @(posedge sys_clk);
    dec_op <= o1; dec_quad <= q1; dec_blk_y <= y1; dec_dst <= d1;
    @(posedge sys_clk);
    dec_op <= o2; dec_quad <= q2; dec_blk_y <= y2; dec_dst <= 5'h1F;
    dec_src_a <= a2; dec_src_b <= b2;
    for (int i = 0; i < 8; i++) begin
      @(negedge sys_clk);
      if (stall_dec !== 1'b1) break;
      check(16'(stage_hold[5:0]), 16'h003F);
      c++;
      @(posedge sys_clk);
    end
    @(posedge sys_clk);
    dec_op <= bps_pkg::BPS_OP_NONE;
    check(16'(c), 16'(n));
  endtask

  // integer writer at predecode, conditional when cc is set, then a reader of it
  task automatic pd_pair(input logic cc, input logic [3:0] n);
    int c;
    c = 0;
    @(posedge sys_clk);
    pd_int_wr <= 1'b1; pd_int_wr_ccmp <= cc; pd_int_dst <= 5'h07;
    @(posedge sys_clk);
    pd_int_wr <= 1'b0; pd_int_use_a <= 1'b1; pd_int_src_a <= 5'h07;
    for (int i = 0; i < 8; i++) begin
      @(negedge sys_clk);
      if (stall_pd !== 1'b1) break;
      check(16'(stage_hold[5:0]), 16'h001F);
      c++;
      @(posedge sys_clk);
    end
    @(posedge sys_clk);
    pd_int_use_a <= 1'b0;
    check(16'(c), 16'(n));
  endtask

  // one conditional branch resolved at decode (x=0) or second execute (x=1)
  task automatic br(input logic x, c, p, h, f, tc, sc, input logic [3:0] cost);
    int         res, m;
    logic [9:0] mask;
    res = x ? 9 : 5;
    m = (cost > res) ? res : cost;
    mask = ((10'h001 << m) - 10'h001) << (res - m);
    @(posedge sys_clk);
    br_d_valid <= !x; br_x_valid <= x; br_d_cmp <= c; br_d_pred <= p; br_x_pred <= p;
    br_d_hit <= h; int_equal_flag <= f; arith_equal_flag <= f;
    br_d_tcross <= tc; br_x_tcross <= tc; br_d_scross <= sc; br_x_scross <= sc;
    @(negedge sys_clk);
    check(16'(stage_void), 16'(mask));
    check(16'(fetch_ready), 16'(cost == 4'h0));
    @(posedge sys_clk);
    br_d_valid <= 1'b0; br_x_valid <= 1'b0;
    @(negedge sys_clk);
    check(16'(fetch_redirect), 16'(cost != 4'h0));
    if (cost != 4'h0) check(16'(void_count), 16'(cost));
    if (m == res) check(16'(stage_valid & mask), 16'h0000);
    check(16'(fetch_ready), 16'(cost <= res));
    repeat (14) @(posedge sys_clk);
  endtask

  // ==================================================================
  // main sequence
  initial begin
    {fetch_valid, pd_int_use_a, pd_int_use_b, pd_int_wr, pd_int_wr_ccmp} = '0;
    {pd_int_src_a, pd_int_src_b, pd_int_dst, dec_dst, dec_src_a, dec_src_b} = '0;
    {dec_quad, dec_blk_y, acc_bus_req, acc_bus_grant, br_d_valid, br_d_cmp} = '0;
    {br_d_pred, br_d_hit, int_equal_flag, br_d_tcross, br_d_scross} = '0;
    {br_x_valid, br_x_pred, arith_equal_flag, br_x_tcross, br_x_scross} = '0;
    dec_op = bps_pkg::BPS_OP_NONE;
    err_total = 0; total_checks = 0; resetn = 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    fetch_valid <= 1'b1;
    // the first line is taken at the edge after fetch_valid is raised
    @(posedge sys_clk);
    // lines march one stage per edge through all ten stages
    for (int k = 1; k <= 10; k++) begin
      @(negedge sys_clk);
      check(16'(stage_valid), 16'((11'h001 << k) - 11'h001));
      @(posedge sys_clk);
    end
    dep(bps_pkg::BPS_OP_STAT_RD, 0, 0, 3, bps_pkg::BPS_OP_COMPUTE, 0, 0, 1, 2, 2);
    dep(bps_pkg::BPS_OP_STAT_RD, 0, 1, 3, bps_pkg::BPS_OP_COMPUTE, 1, 1, 4, 5, 2);
    dep(bps_pkg::BPS_OP_STAT_RD, 0, 0, 3, bps_pkg::BPS_OP_STORE, 0, 0, 3, 0, 1);
    dep(bps_pkg::BPS_OP_STAT_RD, 0, 0, 3, bps_pkg::BPS_OP_STORE, 0, 0, 4, 0, 0);
    dep(bps_pkg::BPS_OP_ACS, 0, 0, 6, bps_pkg::BPS_OP_ACS, 0, 0, 6, 2, 0);
    dep(bps_pkg::BPS_OP_ACS, 1, 0, 6, bps_pkg::BPS_OP_ACS, 1, 0, 6, 2, 0);
    dep(bps_pkg::BPS_OP_ACS_COND, 0, 0, 6, bps_pkg::BPS_OP_CLU, 0, 0, 1, 6, 2);
    dep(bps_pkg::BPS_OP_TRLD_CND, 0, 0, 6, bps_pkg::BPS_OP_DESPREAD, 0, 0, 1, 2, 1);
    dep(bps_pkg::BPS_OP_ACS, 1, 0, 6, bps_pkg::BPS_OP_ACS, 0, 0, 6, 2, 1);
    dep(bps_pkg::BPS_OP_ACS, 0, 0, 6, bps_pkg::BPS_OP_ACS, 1, 0, 6, 2, 1);
    dep(bps_pkg::BPS_OP_ACS, 0, 0, 6, bps_pkg::BPS_OP_ACS, 0, 0, 2, 6, 1);
    dep(bps_pkg::BPS_OP_COMPUTE, 0, 0, 8, bps_pkg::BPS_OP_COMPUTE, 0, 0, 1, 8, 1);
    pd_pair(1'b1, 4'h4);
    pd_pair(1'b0, 4'h0);
    // refused bus grant holds the access stage and everything younger
    @(posedge sys_clk);
    acc_bus_req <= 1'b1;
    @(negedge sys_clk);
    check(16'(stall_acc), 16'h0001);
    check(16'(stage_hold[7:0]), 16'h00FF);
    check(16'(fetch_ready), 16'h0000);
    @(posedge sys_clk);
    acc_bus_grant <= 1'b1;
    @(negedge sys_clk);
    check(16'(stall_acc), 16'h0000);
    @(posedge sys_clk);
    acc_bus_req <= 1'b0;
    br(0, 0, 1, 0, 1, 0, 0, 4'h4);
    br(0, 0, 1, 0, 1, 1, 0, 4'h5);
    br(0, 0, 1, 1, 1, 1, 0, 4'h1);
    br(0, 0, 1, 1, 1, 0, 0, 4'h0);
    br(0, 0, 0, 0, 1, 0, 0, 4'h5);
    br(0, 0, 1, 1, 0, 0, 1, 4'h6);
    br(0, 0, 1, 0, 0, 0, 0, 4'h5);
    br(0, 0, 0, 0, 0, 0, 0, 4'h0);
    br(0, 1, 0, 0, 1, 0, 0, 4'h0);
    br(1, 1, 0, 0, 1, 0, 0, 4'hA);
    br(1, 1, 1, 1, 0, 0, 0, 4'hA);
    br(1, 1, 1, 0, 0, 0, 1, 4'hB);
    complete_run();
  end
endmodule // bps_stall_ctrl_tb
